// ==== cbt_pkg.sv ====
// Package: register map, field layout and types for the CAN bit-timing/flags block
package cbt_pkg;
   // Register byte offsets (AXI4-Lite word aligned)
   localparam logic [7:0] CBT_OFS_NBT_HI   = 8'h00;
   localparam logic [7:0] CBT_OFS_NBT_LO   = 8'h04;
   localparam logic [7:0] CBT_OFS_TXIF_HI  = 8'h08;
   localparam logic [7:0] CBT_OFS_TXIF_LO  = 8'h0c;
   localparam logic [7:0] CBT_OFS_TEF_STA  = 8'h10;
   localparam logic [7:0] CBT_OFS_MODE     = 8'h14;
   localparam logic [7:0] CBT_OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] CBT_OFS_IRQ_MASK = 8'h1c;
   // Field widths and reset values
   localparam int         CBT_SUM_W        = 8;
   localparam logic [7:0] CBT_PRESC_RST    = 8'h00;
   localparam logic [7:0] CBT_SEG1_RST     = 8'h3c;
   localparam logic [6:0] CBT_SEG2_RST     = 7'h0f;
   localparam logic [6:0] CBT_SJW_RST      = 7'h0f;
   localparam logic [2:0] CBT_MODE_CONFIG  = 3'h4;
   localparam logic [2:0] CBT_MODE_RST     = 3'h4;
   // Event status bit positions
   localparam int         CBT_TEF_NE_BIT   = 0;
   localparam int         CBT_TEF_HALF_BIT = 1;
   localparam int         CBT_TEF_FULL_BIT = 2;
   localparam int         CBT_TEF_OV_BIT   = 3;
   // Interrupt status bit positions
   localparam int         CBT_IRQ_OV_BIT   = 0;
   localparam int         CBT_IRQ_TX_BIT   = 1;
   localparam int         CBT_IRQ_W        = 2;
   // AXI response codes
   localparam logic [1:0] CBT_RESP_OKAY    = 2'h0;
   localparam logic [1:0] CBT_RESP_SLVERR  = 2'h2;

   // Bit-time configuration carried to the bit-timing logic
   typedef struct packed {
      logic [7:0] quantum_prescaler;
      logic [7:0] segment_one_length;
      logic [6:0] segment_two_length;
      logic [6:0] jump_width;
   } cbt_cfg_t;

   // Fill state of the transmit event FIFO
   typedef struct packed {
      logic full;
      logic half;
      logic nonempty;
   } cbt_fill_t;

   // Bit-time phases
   typedef enum logic [1:0] {
      CBT_PH_SYNC = 2'b00,
      CBT_PH_SEG1 = 2'b01,
      CBT_PH_SEG2 = 2'b11
   } cbt_phase_t;
endpackage

// ==== cbt_top.sv ====
// CAN nominal bit timing, transmit summary and event-FIFO flags behind AXI4-Lite
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module cbt_top
   import cbt_pkg::*;
(
   input  wire logic                        aclk,          // System clock, 100 MHz
   input  wire logic                        aresetn,       // Synchronous reset, active low
   input  wire logic                        clk_en,        // Freezes all state while low
   input  wire logic [7:0]                  awaddr,        // Write address
   input  wire logic                        awvalid,       // Write address valid
   output logic                             awready,       // Write address ready
   input  wire logic [31:0]                 wdata,         // Write data
   input  wire logic [3:0]                  wstrb,         // Write byte strobes
   input  wire logic                        wvalid,        // Write data valid
   output logic                             wready,        // Write data ready
   output logic [1:0]                       bresp,         // Write response
   output logic                             bvalid,        // Write response valid
   input  wire logic                        bready,        // Write response ready
   input  wire logic [7:0]                  araddr,        // Read address
   input  wire logic                        arvalid,       // Read address valid
   output logic                             arready,       // Read address ready
   output logic [31:0]                      rdata,         // Read data
   output logic [1:0]                       rresp,         // Read response
   output logic                             rvalid,        // Read data valid
   input  wire logic                        rready,        // Read data ready
   input  wire logic [cbt_pkg::CBT_SUM_W-1:0] tx_fifo_flags, // Per-FIFO OR of enabled flags
   input  wire cbt_pkg::cbt_fill_t          tef_fill,      // Event FIFO fill state
   input  wire logic                        tef_overflow,  // Event FIFO overflow pulse
   input  wire logic                        rx_pin,        // CAN receive pin, asynchronous
   output cbt_pkg::cbt_cfg_t                bit_cfg,       // Active bit-time configuration
   output logic                             tq_tick,       // One-cycle pulse per time quantum
   output logic                             sample_point,  // Pulse at end of segment one
   output logic                             bit_end,       // Pulse at end of each bit
   output logic                             irq            // Level interrupt
);
   import cbt_pkg::*;

   // ==========================================================
   // Register state
   cbt_cfg_t                cfg_r;
   logic [2:0]              mode_r;
   logic                    ovf_r;
   logic [CBT_IRQ_W-1:0]    irq_stat_r;
   logic [CBT_IRQ_W-1:0]    irq_mask_r;
   logic [CBT_SUM_W-1:0]    sum_r;
   cbt_fill_t               fill_r;
   logic [7:0]              aw_addr_r;
   logic [31:0]             w_data_r;
   logic [3:0]              w_strb_r;
   logic                    aw_have_r;
   logic                    w_have_r;
   logic                    wr_fire;
   logic                    tx_rise;
   logic [CBT_SUM_W-1:0]    sum_prev_r;
   logic [31:0]             rd_word;
   logic                    rd_hit;

   // ==========================================================
   // AXI4-Lite write channel: address and data in either order
   assign awready = !aw_have_r && !bvalid;
   assign wready  = !w_have_r && !bvalid;
   assign wr_fire = aw_have_r && w_have_r && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= '0;
         w_strb_r  <= '0;
         bvalid    <= 1'b0;
         bresp     <= CBT_RESP_OKAY;
      end else if (clk_en) begin
         if (awvalid && awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid    <= 1'b1;
            // Unmapped addresses answer with an error, nothing stored
            bresp     <= (aw_addr_r > CBT_OFS_IRQ_MASK || aw_addr_r[1:0] != 2'h0)
                         ? CBT_RESP_SLVERR : CBT_RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Bit-time and mode registers
   // Locking outside configuration mode keeps a running bit clock consistent
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r  <= '{CBT_PRESC_RST, CBT_SEG1_RST, CBT_SEG2_RST, CBT_SJW_RST};
         mode_r <= CBT_MODE_RST;
      end else if (clk_en && wr_fire) begin
         if (mode_r == CBT_MODE_CONFIG) begin
            if (aw_addr_r == CBT_OFS_NBT_HI) begin
               if (w_strb_r[1]) cfg_r.quantum_prescaler  <= w_data_r[15:8];
               if (w_strb_r[0]) cfg_r.segment_one_length <= w_data_r[7:0];
            end
            if (aw_addr_r == CBT_OFS_NBT_LO) begin
               if (w_strb_r[1]) cfg_r.segment_two_length <= w_data_r[14:8];
               if (w_strb_r[0]) cfg_r.jump_width         <= w_data_r[6:0];
            end
         end
         if (aw_addr_r == CBT_OFS_MODE && w_strb_r[0])
            mode_r <= w_data_r[2:0];
      end
   end
   assign bit_cfg = cfg_r;

   // ==========================================================
   // Summary and fill tracking, one cycle behind the sources
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sum_r      <= '0;
         sum_prev_r <= '0;
         fill_r     <= '0;
      end else if (clk_en) begin
         sum_r      <= tx_fifo_flags;
         sum_prev_r <= sum_r;
         fill_r     <= tef_fill;
      end
   end
   assign tx_rise = |(sum_r & ~sum_prev_r);

   // ==========================================================
   // Event FIFO overflow flag: set wins over hardware clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_r <= 1'b0;
      end else if (clk_en) begin
         if (tef_overflow)
            ovf_r <= 1'b1;
         else if (wr_fire && aw_addr_r == CBT_OFS_TEF_STA && w_strb_r[0] &&
                  w_data_r[CBT_TEF_OV_BIT])
            ovf_r <= 1'b1;
         else if (!fill_r.full)
            ovf_r <= 1'b0; // Hardware clears once room is back
      end
   end

   // ==========================================================
   // Interrupt status (write one to clear) and mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
      end else if (clk_en) begin
         if (wr_fire && aw_addr_r == CBT_OFS_IRQ_STAT && w_strb_r[0])
            irq_stat_r <= irq_stat_r & ~w_data_r[CBT_IRQ_W-1:0];
         if (wr_fire && aw_addr_r == CBT_OFS_IRQ_MASK && w_strb_r[0])
            irq_mask_r <= w_data_r[CBT_IRQ_W-1:0];
         // Sets placed last so they win over a same-cycle clear
         if (tef_overflow) irq_stat_r[CBT_IRQ_OV_BIT] <= 1'b1;
         if (tx_rise)      irq_stat_r[CBT_IRQ_TX_BIT] <= 1'b1;
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   // ==========================================================
   // Read decode
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      unique case (araddr)
         CBT_OFS_NBT_HI:   rd_word[15:0] = {cfg_r.quantum_prescaler, cfg_r.segment_one_length};
         CBT_OFS_NBT_LO:   rd_word[15:0] = {1'b0, cfg_r.segment_two_length,
                                             1'b0, cfg_r.jump_width};
         CBT_OFS_TXIF_HI:  rd_word = '0;
         CBT_OFS_TXIF_LO:  rd_word[CBT_SUM_W-1:0] = sum_r;
         CBT_OFS_TEF_STA: begin
            rd_word[CBT_TEF_OV_BIT]   = ovf_r;
            rd_word[CBT_TEF_FULL_BIT] = fill_r.full;
            rd_word[CBT_TEF_HALF_BIT] = fill_r.half;
            rd_word[CBT_TEF_NE_BIT]   = fill_r.nonempty;
         end
         CBT_OFS_MODE:     rd_word[2:0] = mode_r;
         CBT_OFS_IRQ_STAT: rd_word[CBT_IRQ_W-1:0] = irq_stat_r;
         CBT_OFS_IRQ_MASK: rd_word[CBT_IRQ_W-1:0] = irq_mask_r;
         default:          rd_hit = 1'b0;
      endcase
   end

   // ==========================================================
   // AXI4-Lite read channel
   assign arready = !rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= CBT_RESP_OKAY;
      end else if (clk_en) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_hit ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Bit timing: quantum prescaler and phase machine
   logic [1:0]  rx_sync_r;
   logic        rx_prev_r;
   logic        rx_fall;
   logic [7:0]  presc_cnt_r;
   logic [8:0]  tq_cnt_r;
   logic [7:0]  seg1_ext_r;
   logic        rx_edge_r;
   logic        rx_seen;
   logic        seg1_done;
   logic        seg2_done;
   cbt_phase_t  phase_r;
   logic        run;

   // Pin passes two flops; only the second is looked at
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sync_r <= 2'b11;
         rx_prev_r <= 1'b1;
      end else if (clk_en) begin
         rx_sync_r <= {rx_sync_r[0], rx_pin};
         rx_prev_r <= rx_sync_r[1];
      end
   end
   assign rx_fall = rx_prev_r && !rx_sync_r[1];
   assign run     = mode_r != CBT_MODE_CONFIG;

   // Edge held until the next quantum, so a slow prescaler cannot miss it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_edge_r <= 1'b0;
      end else if (clk_en) begin
         if (!run || tq_tick)
            rx_edge_r <= 1'b0;
         else if (rx_fall)
            rx_edge_r <= 1'b1;
      end
   end
   assign rx_seen   = rx_fall || rx_edge_r;
   // Nine bits: segment one plus a full lengthening runs past 255
   assign seg1_done = tq_cnt_r >= {1'b0, cfg_r.segment_one_length} + {1'b0, seg1_ext_r};
   // Early edge cuts segment two by no more than the jump width plus one quantum
   assign seg2_done = tq_cnt_r == {2'b00, cfg_r.segment_two_length} ||
                      (rx_seen && {2'b00, cfg_r.segment_two_length} - tq_cnt_r <=
                       {2'b00, cfg_r.jump_width} + 9'h001);

   // Quantum is prescaler + 1 system clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_cnt_r <= '0;
      end else if (clk_en) begin
         if (!run || presc_cnt_r == cfg_r.quantum_prescaler)
            presc_cnt_r <= '0;
         else
            presc_cnt_r <= presc_cnt_r + 8'h01;
      end
   end
   assign tq_tick = run && presc_cnt_r == cfg_r.quantum_prescaler;

   // Sync, segment one (+ lengthening), segment two (shortened on early edge)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r    <= CBT_PH_SYNC;
         tq_cnt_r   <= '0;
         seg1_ext_r <= '0;
      end else if (clk_en) begin
         if (!run) begin
            phase_r    <= CBT_PH_SYNC;
            tq_cnt_r   <= '0;
            seg1_ext_r <= '0;
         end else if (tq_tick) begin
            unique case (phase_r)
               CBT_PH_SYNC: begin
                  phase_r  <= CBT_PH_SEG1;
                  tq_cnt_r <= '0;
               end
               CBT_PH_SEG1: begin
                  if (rx_seen && seg1_ext_r == 8'h00)
                     seg1_ext_r <= {1'b0, cfg_r.jump_width} + 8'h01;
                  if (seg1_done) begin
                     phase_r    <= CBT_PH_SEG2;
                     tq_cnt_r   <= '0;
                     seg1_ext_r <= '0;
                  end else begin
                     tq_cnt_r <= tq_cnt_r + 9'h001;
                  end
               end
               CBT_PH_SEG2: begin
                  // Early edge ends the bit sooner, limited resync
                  if (seg2_done) begin
                     phase_r  <= CBT_PH_SYNC;
                     tq_cnt_r <= '0;
                  end else begin
                     tq_cnt_r <= tq_cnt_r + 9'h001;
                  end
               end
               default: phase_r <= CBT_PH_SYNC;
            endcase
         end
      end
   end
   assign sample_point = tq_tick && phase_r == CBT_PH_SEG1 && seg1_done;
   assign bit_end      = tq_tick && phase_r == CBT_PH_SEG2 && seg2_done;

   // ==========================================================
   // Assertions
   a_cfg_locked_run: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && mode_r != CBT_MODE_CONFIG) |=> $stable(cfg_r))
      else $error("bit-time config changed outside configuration mode");

   a_tq_period: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && presc_cnt_r == 8'h00 && run && cfg_r.quantum_prescaler == 8'h01)
      |-> ##1 (!clk_en || !run || tq_tick))
      else $error("quantum length wrong for prescaler one");

   a_summary_track: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> (sum_r == $past(tx_fifo_flags)))
      else $error("summary bits do not follow the FIFO flags");

   a_full_track: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> (fill_r.full == $past(tef_fill.full)))
      else $error("full flag does not track FIFO");

   a_half_track: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> (fill_r.half == $past(tef_fill.half)))
      else $error("half flag does not track FIFO");

   a_nonempty_track: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> (fill_r.nonempty == $past(tef_fill.nonempty)))
      else $error("nonempty flag does not track FIFO");

   a_ovf_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && tef_overflow) |=> ovf_r && irq_stat_r[CBT_IRQ_OV_BIT])
      else $error("overflow event not flagged");

   a_high_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && arvalid && arready &&
       (araddr == CBT_OFS_TXIF_HI || araddr == CBT_OFS_TXIF_LO))
      |=> (rdata[31:CBT_SUM_W] == '0))
      else $error("upper summary bits not zero");

   sequence s_seg2_entry;
      tq_tick && phase_r == CBT_PH_SEG1 ##1 phase_r == CBT_PH_SEG2;
   endsequence
   a_sync_first: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && tq_tick && phase_r == CBT_PH_SYNC && run) |=> phase_r == CBT_PH_SEG1)
      else $error("sync quantum not followed by segment one");

   a_seg2_counter: assert property (@(posedge aclk) disable iff (!aresetn)
      s_seg2_entry |-> tq_cnt_r == 9'h000)
      else $error("segment two count not restarted");
endmodule

// ==== cbt_can_node.sv ====
// Far-side model: CAN node on the receive pin and the event FIFO fill source
`timescale 1ns/10ps
module cbt_can_node
   import cbt_pkg::*;
#(
   parameter int DEPTH = 8                    // Event FIFO entries
)(
   input  wire logic          aclk,           // System clock
   input  wire logic          aresetn,        // Reset, active low
   input  wire logic          active,         // Bus traffic on
   input  wire logic          push,           // Event stored
   input  wire logic          pop,            // Event read out
   output logic               rx_pin,         // Bus level, 1 = recessive
   output cbt_pkg::cbt_fill_t tef_fill,       // FIFO fill state
   output logic               tef_overflow    // Push into a full FIFO
);
   int cnt;
   int wait_c;
   // ====================
   // Bus traffic
   // Idle bus is recessive, so a quiet node leaves the pin high
   always_ff @(posedge aclk) begin
      if (!aresetn || !active) begin
         rx_pin <= 1'b1;
         wait_c <= 8;
      end else if (wait_c == 0) begin
         rx_pin <= ~rx_pin;
         wait_c <= 5 + int'($urandom_range(60));
      end else begin
         wait_c <= wait_c - 1;
      end
   end
   // ====================
   // Event FIFO
   // A push into a full FIFO is lost and reported for one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 0;
         tef_overflow <= 1'b0;
      end else begin
         tef_overflow <= push && cnt == DEPTH;
         cnt <= cnt + int'(push && cnt < DEPTH) - int'(pop && cnt > 0);
      end
   end
   assign tef_fill = {cnt == DEPTH, cnt >= DEPTH / 2, cnt != 0};
endmodule

// ==== cbt_top_bench.sv ====
// Self-checking bench for the CAN bit-timing and transmit flag block
`timescale 1ns/10ps
module cbt_top_bench;
   import cbt_pkg::*;
   localparam int         DEPTH     = 8;
   localparam logic [7:0] CORNER[4] = '{8'h01, 8'h80, 8'hff, 8'h00};
   localparam int         STEPS[4]  = '{1, 3, 4, 1};
   logic        aclk;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, push = 1'b0, pop = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, active = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx_fifo_flags = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awready, wready, bvalid, arready, rvalid, tef_overflow, rx_pin;
   logic        tq_tick, sample_point, bit_end, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [2:0]  pulses;
   cbt_fill_t   tef_fill;
   cbt_cfg_t    bit_cfg;
   int          err_count = 0;
   int          n_tests = 0;
   // ====================
   // Block and its far side
   cbt_top i_cbt_top (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .tx_fifo_flags(tx_fifo_flags), .tef_fill(tef_fill), .tef_overflow(tef_overflow),
      .rx_pin(rx_pin), .bit_cfg(bit_cfg), .tq_tick(tq_tick), .sample_point(sample_point),
      .bit_end(bit_end), .irq(irq)
   );
   cbt_can_node #(.DEPTH(DEPTH)) i_cbt_can_node (
      .aclk(aclk), .aresetn(aresetn), .active(active), .push(push), .pop(pop),
      .rx_pin(rx_pin), .tef_fill(tef_fill), .tef_overflow(tef_overflow)
   );
   assign pulses = {sample_point, bit_end, tq_tick};
   // Clock, 10 ns period
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ====================
   // Expectations and checks
   function automatic logic [31:0] exp_bit(input logic [31:0] h, input logic [31:0] l);
      return (32'(h[15:8]) + 1) * (32'(h[7:0]) + 32'(l[14:8]) + 3);
   endfunction
   function automatic logic [31:0] exp_sta(input int c, input logic ov);
      return {28'h0, ov, c >= DEPTH, c >= DEPTH / 2, c > 0};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ====================
   // Bus master; response code 3 never comes back, so it marks a pending answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
         end
      end
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [1:0]  r;
      logic [31:0] d;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            r = rresp;
            d = rdata;
            rready <= 1'b0;
         end
      end
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask
   // Cycles from one pulse of the chosen strobe to the next
   task automatic gap(input int k, output int n);
      n = 0;
      while (pulses[k] !== 1'b1 && n < 4000) begin
         @(posedge aclk);
         n++;
      end
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (pulses[k] !== 1'b1 && n < 4000);
   endtask
   task automatic fifo(input int k, input logic up);
      repeat (k) begin
         @(posedge aclk);
         {push, pop} <= up ? 2'b10 : 2'b01;
      end
      @(posedge aclk);
      {push, pop} <= 2'b00;
      // Overflow clear follows the registered fill state one cycle later
      @(posedge aclk);
   endtask
   // ====================
   // Main sequence
   initial begin
      logic [31:0] hi;
      logic [31:0] lo;
      logic [7:0]  flags;
      int          n;
      int          cnt;
      void'($urandom(52));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CBT_OFS_NBT_HI, {24'h0, CBT_SEG1_RST}, CBT_RESP_OKAY);
      rd(CBT_OFS_NBT_LO, 32'h0f0f, CBT_RESP_OKAY);
      rd(CBT_OFS_TEF_STA, 32'h0, CBT_RESP_OKAY);
      // Bit timing: slowest quantum with shortest segments first, then random
      // Segment two kept short so a slow bit stays inside the gap limit
      for (int i = 0; i < 3; i++) begin
         hi = {16'($urandom), 8'($urandom), 6'h0, 2'($urandom)};
         lo = $urandom & 32'hffff_07ff;
         if (i == 0) hi = 32'hffff_ff00;
         if (i == 0) lo = 32'h0;
         if (i == 1) hi[15:8] = 8'h01;
         wr(CBT_OFS_MODE, {29'h0, CBT_MODE_CONFIG}, CBT_RESP_OKAY);
         wr(CBT_OFS_NBT_HI, hi, CBT_RESP_OKAY);
         wr(CBT_OFS_NBT_LO, lo, CBT_RESP_OKAY);
         rd(CBT_OFS_NBT_LO, lo & 32'h7f7f, CBT_RESP_OKAY);
         chk({2'h0, bit_cfg}, {2'h0, hi[15:0], lo[14:8], lo[6:0]});
         wr(CBT_OFS_MODE, 32'h0, CBT_RESP_OKAY);
         wr(CBT_OFS_NBT_HI, ~hi, CBT_RESP_OKAY);
         rd(CBT_OFS_NBT_HI, hi & 32'hffff, CBT_RESP_OKAY);
         gap(0, n);
         chk(n, 32'(hi[15:8]) + 1);
         gap(1, n);
         chk(n, exp_bit(hi, lo));
         gap(2, n);
         chk(n, exp_bit(hi, lo));
      end
      // Receive edges let the resync path run for a while
      active <= 1'b1;
      repeat (3000) @(posedge aclk);
      active <= 1'b0;
      // Transmit summary, random then corners, ending with all flags gone
      for (int i = 0; i < 10; i++) begin
         flags = (i < 6) ? 8'($urandom) : CORNER[i-6];
         tx_fifo_flags <= flags;
         rd(CBT_OFS_TXIF_LO, {24'h0, flags}, CBT_RESP_OKAY);
         rd(CBT_OFS_TXIF_HI, 32'h0, CBT_RESP_OKAY);
      end
      // Event FIFO filled past full, then software pokes the status bits
      cnt = 0;
      for (int i = 0; i < 4; i++) begin
         fifo(STEPS[i], 1'b1);
         cnt += STEPS[i];
         rd(CBT_OFS_TEF_STA, exp_sta(cnt, cnt > DEPTH), CBT_RESP_OKAY);
      end
      wr(CBT_OFS_TEF_STA, 32'h7, CBT_RESP_OKAY);
      rd(CBT_OFS_TEF_STA, exp_sta(DEPTH, 1'b1), CBT_RESP_OKAY);
      wr(CBT_OFS_IRQ_MASK, 32'h0, CBT_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(CBT_OFS_IRQ_MASK, 32'h1, CBT_RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(CBT_OFS_IRQ_STAT, 32'h3, CBT_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      fifo(1, 1'b0);
      rd(CBT_OFS_TEF_STA, exp_sta(DEPTH - 1, 1'b0), CBT_RESP_OKAY);
      fifo(1, 1'b1);
      rd(CBT_OFS_TEF_STA, exp_sta(DEPTH, 1'b0), CBT_RESP_OKAY);
      wr(CBT_OFS_TEF_STA, 32'h8, CBT_RESP_OKAY);
      rd(CBT_OFS_TEF_STA, exp_sta(DEPTH, 1'b1), CBT_RESP_OKAY);
      fifo(DEPTH, 1'b0);
      rd(CBT_OFS_TEF_STA, exp_sta(0, 1'b0), CBT_RESP_OKAY);
      // Unmapped and misaligned places are refused
      rd(8'h20, 32'h0, CBT_RESP_SLVERR);
      wr(8'h24, $urandom, CBT_RESP_SLVERR);
      rd(8'h02, 32'h0, CBT_RESP_SLVERR);
      results();
   end
   // Watchdog, well beyond the longest expected run
   initial begin
      repeat (60000) @(posedge aclk);
      err_count++;
      results();
   end
endmodule
